// file: rtl/dcf_defs.svh
// Purpose: constants of the dual-clock buffer with programmable flags
// Assumes: a single core clock of 40 MHz samples both link clocks
// Notes:   times are kept in ns; the replay recovery time is turned into core cycles here
`ifndef DCF_DEFS_SVH
`define DCF_DEFS_SVH
`define DCF_WIDTH               18
`define DCF_DEPTH               16384
`define DCF_OFFSET_WIDTH        14
`define DCF_OFFSET_DEFAULT      14'h007F
`define DCF_STAGE_DEPTH         16
`define DCF_SYNC_STAGES         2
`define DCF_MCLK_PERIOD_NS      25
`define DCF_FULL_FLAG_SKEW_NS   5
`define DCF_EMPTY_FLAG_SKEW_NS  5
`define DCF_ALMOST_FLAG_SKEW_NS 15
`define DCF_REPLAY_RECOVERY_NS  60
`define DCF_REPLAY_RECOVERY_CYC \
	((`DCF_REPLAY_RECOVERY_NS + `DCF_MCLK_PERIOD_NS - 1) / `DCF_MCLK_PERIOD_NS)
`endif

// file: rtl/dcf_pkg.sv
// Purpose: shared types of the dual-clock buffer
// Assumes: nothing beyond the constants header
// Notes:   offset selectors are one-hot
package dcf_pkg;
	// which offset register the next program access touches
	typedef enum logic [1:0]
	{
		DCF_SEL_EMPTY = 2'b01,
		DCF_SEL_FULL  = 2'b10
	} dcf_sel_type;

	// all pins that arrive from outside the core clock domain
	typedef struct packed
	{
		logic        replay;
		logic        sync_sel;
		logic        out_en_n;
		logic        load_n;
		logic        read_en_n;
		logic        write_en_n;
		logic        read_clk;
		logic        write_clk;
		logic [17:0] data;
	} dcf_pins_type;

	// the five status flags, all active low
	typedef struct packed
	{
		logic empty_n;
		logic almost_empty_n;
		logic half_full_n;
		logic almost_full_n;
		logic full_n;
	} dcf_flags_type;
endpackage : dcf_pkg

// file: rtl/dcf_gray_sync.sv
// Purpose: carry a pointer to the other side as gray code through two flops
// Assumes: the source pointer moves by at most one per cycle
// Notes:   output is binary, two cycles behind the gray register
`timescale 1ns/1ps
module dcf_gray_sync #(parameter int W = 15)
(
	input  wire logic         clk,
	input  wire logic         arst_n,
	input  wire logic         cke,
	input  wire logic [W-1:0] bin_in,
	output logic      [W-1:0] bin_out
);
	logic [W-1:0] gray_r; // gray copy held on the source side
	logic [W-1:0] meta_r; // first stage, read only by sync_r
	logic [W-1:0] sync_r; // settled gray value

	// encode then pass two flops; one bit changes per step, so no torn word
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			gray_r <= '0;
			meta_r <= '0;
			sync_r <= '0;
		end
		else if (cke)
		begin
			gray_r <= bin_in ^ (bin_in >> 1);
			meta_r <= gray_r;
			sync_r <= meta_r;
		end
	end

	// decode: each binary bit is the parity of the gray bits at and above it
	for (genvar i = 0; i < W; i++)
	begin : g_dec
		assign bin_out[i] = ^sync_r[W-1:i];
	end
endmodule : dcf_gray_sync

// file: rtl/dcf_stage_fifo.sv
// Purpose: small staging buffer with valid/ready on both sides
// Assumes: depth is a power of two
// Notes:   read data is shown combinationally from the head entry
`timescale 1ns/1ps
module dcf_stage_fifo #(parameter int WIDTH = 18, parameter int DEPTH = 16)
(
	input  wire logic             clk,
	input  wire logic             arst_n,
	input  wire logic             cke,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH)
	begin : g_chk
		$error("stage depth must be a power of two");
	end

	logic [WIDTH-1:0] mem [DEPTH]; // entries
	logic [AW:0]      wr_r;        // fill pointer with lap bit
	logic [AW:0]      rd_r;        // drain pointer with lap bit

	// honest flags: same index, laps differ means full
	assign in_ready  = (wr_r ^ rd_r) != {1'b1, {AW{1'b0}}};
	assign out_valid = wr_r != rd_r;
	assign out_data  = mem[rd_r[AW-1:0]];

	// entry storage, no reset needed
	always_ff @(posedge clk)
	begin
		if (cke && in_valid && in_ready)
			mem[wr_r[AW-1:0]] <= in_data;
	end

	// pointer movement
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wr_r <= '0;
			rd_r <= '0;
		end
		else if (cke)
		begin
			if (in_valid && in_ready)
				wr_r <= wr_r + 1'b1;
			if (out_valid && out_ready)
				rd_r <= rd_r + 1'b1;
		end
	end
endmodule : dcf_stage_fifo

// file: rtl/dcf_buffer.sv
// Purpose: deep dual-clock buffer, 18 bits wide, with five status flags
// Assumes: both link clocks are far slower than MCLK and sampled by it
// Notes:   data, full and empty move only on detected link clock rises
`timescale 1ns/1ps
`include "dcf_defs.svh"
module dcf_buffer import dcf_pkg::*;
#(
	parameter int DEPTH = `DCF_DEPTH,
	parameter int WIDTH = `DCF_WIDTH
)
(
	input  wire logic             MCLK,
	input  wire logic             ARST_N,
	input  wire logic             CKE,
	input  wire logic             WRITE_CLK,
	input  wire logic             READ_CLK,
	input  wire logic             WRITE_EN_N,
	input  wire logic             READ_EN_N,
	input  wire logic             OFFSET_LOAD_N,
	input  wire logic             OUT_EN_N,
	input  wire logic             SYNC_FLAG_SELECT,
	input  wire logic             REPLAY_PULSE,
	input  wire logic [WIDTH-1:0] DATA_IN,
	output logic      [WIDTH-1:0] DATA_OUT,
	output logic                  DATA_OUT_OE,
	output logic                  EMPTY_FLAG_N,
	output logic                  ALMOST_EMPTY_FLAG_N,
	output logic                  HALF_FULL_FLAG_N,
	output logic                  ALMOST_FULL_FLAG_N,
	output logic                  FULL_FLAG_N
);
	localparam int AW = $clog2(DEPTH); // array address width
	localparam int PW = AW + 1;        // pointer width with lap bit
	localparam int OW = `DCF_OFFSET_WIDTH;
	localparam int RECOVERY_CYC = `DCF_REPLAY_RECOVERY_CYC;

	// only the two documented depths and the 18-bit word are served
	if ((DEPTH != 8192 && DEPTH != 16384) || WIDTH != 18)
	begin : g_chk
		$error("depth must be 8192 or 16384 and width 18");
	end

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers and link clock edges

	dcf_pins_type  pins;       // raw pins
	dcf_pins_type  pin_meta_r; // first stage, read only by pin_sync_r
	dcf_pins_type  pin_sync_r; // settled pins
	logic          wclk_d_r;   // delayed write clock for edge find
	logic          rclk_d_r;   // delayed read clock for edge find
	logic          replay_d_r; // delayed replay for edge find
	logic          wclk_rise;  // write clock rose
	logic          rclk_rise;  // read clock rose
	logic          replay_rise;
	// pins leave reset idle, so no enable looks active and outputs stay off
	localparam dcf_pins_type PIN_IDLE = '{replay: 1'b0, sync_sel: 1'b0,
		out_en_n: 1'b1, load_n: 1'b1, read_en_n: 1'b1, write_en_n: 1'b1,
		read_clk: 1'b0, write_clk: 1'b0, data: 18'h00000};

	assign pins = '{replay: REPLAY_PULSE, sync_sel: SYNC_FLAG_SELECT,
		out_en_n: OUT_EN_N, load_n: OFFSET_LOAD_N, read_en_n: READ_EN_N,
		write_en_n: WRITE_EN_N, read_clk: READ_CLK, write_clk: WRITE_CLK,
		data: DATA_IN};

	// every pin, clocks included, passes two flops; the clocks keep
	// running through reset, yet these flops are held at PIN_IDLE while ARST_N is low
	always_ff @(posedge MCLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			pin_meta_r <= PIN_IDLE;
			pin_sync_r <= PIN_IDLE;
			wclk_d_r   <= 1'b0;
			rclk_d_r   <= 1'b0;
			replay_d_r <= 1'b0;
		end
		else if (CKE)
		begin
			pin_meta_r <= pins;
			pin_sync_r <= pin_meta_r;
			wclk_d_r   <= pin_sync_r.write_clk;
			rclk_d_r   <= pin_sync_r.read_clk;
			replay_d_r <= pin_sync_r.replay;
		end
	end

	// data and enables share the clock's sync delay, so setup holds
	assign wclk_rise   = pin_sync_r.write_clk & ~wclk_d_r;
	assign rclk_rise   = pin_sync_r.read_clk & ~rclk_d_r;
	assign replay_rise = pin_sync_r.replay & ~replay_d_r;

	////////////////////////////////////////////////////////////////////////////
	// shared state

	logic [WIDTH-1:0] mem [DEPTH];     // main dual-port array
	logic [PW-1:0]    wptr_r;          // accepted writes
	logic [PW-1:0]    mptr_r;          // writes committed to the array
	logic [PW-1:0]    rptr_r;          // read pointer
	logic [PW-1:0]    rptr_ws;         // read pointer seen by write side
	logic [PW-1:0]    mptr_rs;         // committed pointer seen by read side
	logic [OW-1:0]    ae_off_r;        // almost_empty_distance
	logic [OW-1:0]    af_off_r;        // almost_full_distance
	dcf_sel_type      wsel_r;          // next offset to write
	dcf_sel_type      rsel_r;          // next offset to read back
	dcf_flags_type    flags_r;         // flag flops driving the pins
	logic [WIDTH-1:0] q_r;             // output register
	logic             oe_r;            // output drive enable
	logic [1:0]       rec_cnt_r;       // replay recovery counter
	logic             replay_busy;     // replay or its recovery
	logic             stage_in_ready;  // staging buffer has room
	logic             stage_out_valid; // staging buffer has a word
	logic [WIDTH-1:0] stage_out_data;  // staged word

	assign replay_busy = pin_sync_r.replay | (rec_cnt_r != 2'h0);

	////////////////////////////////////////////////////////////////////////////
	// write side

	logic          wr_take;   // normal write accepted
	logic          prog_wr;   // offset register write
	logic [PW-1:0] wptr_nxt;  // pointer after this edge
	logic [15:0]   wcount;    // words held, write-side view
	logic [15:0]   af_level;  // count at which almost-full asserts

	// a full flag blocks the write whatever the enable says
	assign wr_take = wclk_rise & ~pin_sync_r.write_en_n & pin_sync_r.load_n
		& flags_r.full_n & stage_in_ready;
	assign prog_wr = wclk_rise & ~pin_sync_r.write_en_n & ~pin_sync_r.load_n;
	assign wptr_nxt = wptr_r + PW'(wr_take);
	assign wcount   = 16'(PW'(wptr_nxt - rptr_ws));
	assign af_level = 16'(DEPTH) - 16'(af_off_r);

	// accepted-write pointer
	always_ff @(posedge MCLK or negedge ARST_N)
	begin
		if (!ARST_N)
			wptr_r <= '0;
		else if (CKE)
			wptr_r <= wptr_nxt;
	end

	// words enter a staging buffer before the array; if it ever fills,
	// the write is refused exactly like a write while full
	dcf_stage_fifo #(.WIDTH(WIDTH), .DEPTH(`DCF_STAGE_DEPTH)) u_stage
	(
		.clk       (MCLK),
		.arst_n    (ARST_N),
		.cke       (CKE),
		.in_valid  (wr_take),
		.in_ready  (stage_in_ready),
		.in_data   (pin_sync_r.data),
		.out_valid (stage_out_valid),
		.out_ready (~replay_busy),
		.out_data  (stage_out_data)
	);

	// commit into the array; held off while a replay settles
	always_ff @(posedge MCLK)
	begin
		if (CKE && stage_out_valid && !replay_busy)
			mem[mptr_r[AW-1:0]] <= stage_out_data;
	end

	// committed pointer, the one the read side trusts
	always_ff @(posedge MCLK or negedge ARST_N)
	begin
		if (!ARST_N)
			mptr_r <= '0;
		else if (CKE && stage_out_valid && !replay_busy)
			mptr_r <= mptr_r + 1'b1;
	end

	// offset programming walks empty, full, empty ... and keeps its
	// place across load releases
	always_ff @(posedge MCLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			ae_off_r <= `DCF_OFFSET_DEFAULT;
			af_off_r <= `DCF_OFFSET_DEFAULT;
			wsel_r   <= DCF_SEL_EMPTY;
		end
		else if (CKE && prog_wr)
		begin
			unique case (wsel_r)
				DCF_SEL_EMPTY:
				begin
					ae_off_r <= pin_sync_r.data[OW-1:0];
					wsel_r   <= DCF_SEL_FULL;
				end
				DCF_SEL_FULL:
				begin
					af_off_r <= pin_sync_r.data[OW-1:0];
					wsel_r   <= DCF_SEL_EMPTY;
				end
				default:
					wsel_r <= DCF_SEL_EMPTY;
			endcase
		end
	end

	// read pointer carried to the write side, three cycles late, so a read
	// just before a write rise frees the full flag one edge later
	dcf_gray_sync #(.W(PW)) u_rptr_sync
	(
		.clk     (MCLK),
		.arst_n  (ARST_N),
		.cke     (CKE),
		.bin_in  (rptr_r),
		.bin_out (rptr_ws)
	);

	////////////////////////////////////////////////////////////////////////////
	// read side

	logic          rd_take;   // normal read accepted
	logic          prog_rd;   // offset read back
	logic [PW-1:0] rptr_nxt;  // pointer after this edge
	logic [15:0]   rcount;    // words held, read-side view

	// an empty flag blocks the read whatever the enable says
	assign rd_take = rclk_rise & ~pin_sync_r.read_en_n & pin_sync_r.load_n
		& flags_r.empty_n;
	assign prog_rd  = rclk_rise & ~pin_sync_r.read_en_n & ~pin_sync_r.load_n;
	assign rptr_nxt = rptr_r + PW'(rd_take);
	assign rcount   = 16'(PW'(mptr_rs - rptr_nxt));

	// committed pointer carried to the read side; a write just before a
	// read rise shows up one read edge late
	dcf_gray_sync #(.W(PW)) u_wptr_sync
	(
		.clk     (MCLK),
		.arst_n  (ARST_N),
		.cke     (CKE),
		.bin_in  (mptr_r),
		.bin_out (mptr_rs)
	);

	// read pointer; replay sends it back to the first location, which
	// is only meaningful while no more than a full depth was written
	always_ff @(posedge MCLK or negedge ARST_N)
	begin
		if (!ARST_N)
			rptr_r <= '0;
		else if (CKE)
		begin
			if (replay_rise)
				rptr_r <= '0;
			else
				rptr_r <= rptr_nxt;
		end
	end

	// replay recovery: array commits wait until the pointers settle
	always_ff @(posedge MCLK or negedge ARST_N)
	begin
		if (!ARST_N)
			rec_cnt_r <= 2'h0;
		else if (CKE)
		begin
			if (pin_sync_r.replay)
				rec_cnt_r <= 2'(RECOVERY_CYC);
			else if (rec_cnt_r != 2'h0)
				rec_cnt_r <= rec_cnt_r - 2'h1;
		end
	end

	// all five flags in one process, so the flag word has a single driver;
	// full and empty move only on their own link rises, almost flags also
	// every cycle in free mode so a new offset shows within one cycle
	always_ff @(posedge MCLK or negedge ARST_N)
	begin
		if (!ARST_N)
			flags_r <= '{empty_n: 1'b0, almost_empty_n: 1'b0, half_full_n: 1'b1,
				almost_full_n: 1'b1, full_n: 1'b1};
		else if (CKE)
		begin
			if (wclk_rise)
				flags_r.full_n <= wcount != 16'(DEPTH);
			if (pin_sync_r.sync_sel || wclk_rise)
				flags_r.almost_full_n <= ~(wcount >= af_level);
			// half full tracks the write-side count without waiting for an edge
			flags_r.half_full_n <= ~(wcount > 16'(DEPTH / 2));
			if (rclk_rise)
				flags_r.empty_n <= rcount != 16'h0000;
			if (pin_sync_r.sync_sel || rclk_rise)
				flags_r.almost_empty_n <= ~(rcount <= 16'(ae_off_r));
		end
	end

	// output register: next word, an offset, or hold the last valid word
	always_ff @(posedge MCLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			q_r    <= '0;
			rsel_r <= DCF_SEL_EMPTY;
		end
		else if (CKE)
		begin
			if (rd_take)
				q_r <= mem[rptr_r[AW-1:0]];
			else if (prog_rd)
			begin
				// offsets come back in the order they are written
				q_r    <= WIDTH'((rsel_r == DCF_SEL_FULL) ? af_off_r : ae_off_r);
				rsel_r <= (rsel_r == DCF_SEL_FULL) ? DCF_SEL_EMPTY : DCF_SEL_FULL;
			end
			// a refused read leaves q_r alone
		end
	end

	// output enable follows the pin; off while reset is held
	always_ff @(posedge MCLK or negedge ARST_N)
	begin
		if (!ARST_N)
			oe_r <= 1'b0;
		else if (CKE)
			oe_r <= ~pin_sync_r.out_en_n;
	end

	////////////////////////////////////////////////////////////////////////////
	// pins, all straight from flops

	assign DATA_OUT            = q_r;
	assign DATA_OUT_OE         = oe_r;
	assign EMPTY_FLAG_N        = flags_r.empty_n;
	assign ALMOST_EMPTY_FLAG_N = flags_r.almost_empty_n;
	assign HALF_FULL_FLAG_N    = flags_r.half_full_n;
	assign ALMOST_FULL_FLAG_N  = flags_r.almost_full_n;
	assign FULL_FLAG_N         = flags_r.full_n;
endmodule : dcf_buffer

// file: tb/dcf_buffer_assertions.sv
// Purpose: concurrent checks on the pins of the dual-clock buffer
// Assumes: link clocks far slower than MCLK and sampled by it
// Notes:   a link rise counts as seen when it lies 1..4 samples back
`timescale 1ns/1ps
module dcf_chk import dcf_pkg::*;
#(
	parameter int WIDTH = 18
)
(
	input wire logic             MCLK,
	input wire logic             ARST_N,
	input wire logic             WRITE_CLK,
	input wire logic             READ_CLK,
	input wire logic             OFFSET_LOAD_N,
	input wire logic             OUT_EN_N,
	input wire logic             SYNC_FLAG_SELECT,
	input wire logic [WIDTH-1:0] DATA_OUT,
	input wire logic             DATA_OUT_OE,
	input wire logic             EMPTY_FLAG_N,
	input wire logic             ALMOST_EMPTY_FLAG_N,
	input wire logic             HALF_FULL_FLAG_N,
	input wire logic             ALMOST_FULL_FLAG_N,
	input wire logic             FULL_FLAG_N
);
	////////////////////////////////////////////////////////////
	logic [5:0] wck_h;  // recent write clock samples
	logic [5:0] rck_h;  // recent read clock samples
	logic       w_rise; // write rise lies in the reaction window
	logic       r_rise; // read rise lies in the reaction window
	// no reset: the history is full long before reset is released
	always_ff @(posedge MCLK)
	begin
		wck_h <= {wck_h[4:0], WRITE_CLK};
		rck_h <= {rck_h[4:0], READ_CLK};
	end
	// window allows one cycle of slack early and two late on the sync delay
	assign w_rise = |(wck_h[4:1] & ~wck_h[5:2]);
	assign r_rise = |(rck_h[4:1] & ~rck_h[5:2]);
	////////////////////////////////////////////////////////////
	default clocking dc @(posedge MCLK); endclocking
	default disable iff (!ARST_N);
	reset_state_a: assert property (
		$rose(ARST_N) |-> !EMPTY_FLAG_N && FULL_FLAG_N && !DATA_OUT_OE && DATA_OUT == '0)
		else $error("state after reset wrong");
	oe_on_a: assert property (!OUT_EN_N [*6] |-> DATA_OUT_OE)
		else $error("outputs not driven");
	oe_off_a: assert property (OUT_EN_N [*6] |-> !DATA_OUT_OE)
		else $error("outputs not floated");
	oe_reset_a: assert property ($rose(ARST_N) && OUT_EN_N |=> !DATA_OUT_OE [*2])
		else $error("outputs driven after reset");
	empty_edge_a: assert property ($changed(EMPTY_FLAG_N) |-> r_rise)
		else $error("empty flag moved off read edge");
	full_edge_a: assert property ($changed(FULL_FLAG_N) |-> w_rise)
		else $error("full flag moved off write edge");
	dout_edge_a: assert property ($changed(DATA_OUT) |-> r_rise)
		else $error("data out moved off read edge");
	dout_hold_a: assert property (
		!EMPTY_FLAG_N && OFFSET_LOAD_N |=> $stable(DATA_OUT))
		else $error("data out changed while empty");
	full_flags_a: assert property (
		!FULL_FLAG_N |-> !ALMOST_FULL_FLAG_N && !HALF_FULL_FLAG_N && EMPTY_FLAG_N)
		else $error("flags disagree with full");
	ae_sync_a: assert property (
		!SYNC_FLAG_SELECT && $changed(ALMOST_EMPTY_FLAG_N) |-> r_rise)
		else $error("almost empty moved off read edge");
	af_sync_a: assert property (
		!SYNC_FLAG_SELECT && $changed(ALMOST_FULL_FLAG_N) |-> w_rise)
		else $error("almost full moved off write edge");
endmodule : dcf_chk

bind dcf_buffer dcf_chk #(.WIDTH(WIDTH)) u_chk
(
	.MCLK(MCLK), .ARST_N(ARST_N), .WRITE_CLK(WRITE_CLK), .READ_CLK(READ_CLK),
	.OFFSET_LOAD_N(OFFSET_LOAD_N), .OUT_EN_N(OUT_EN_N),
	.SYNC_FLAG_SELECT(SYNC_FLAG_SELECT), .DATA_OUT(DATA_OUT), .DATA_OUT_OE(DATA_OUT_OE),
	.EMPTY_FLAG_N(EMPTY_FLAG_N), .ALMOST_EMPTY_FLAG_N(ALMOST_EMPTY_FLAG_N),
	.HALF_FULL_FLAG_N(HALF_FULL_FLAG_N), .ALMOST_FULL_FLAG_N(ALMOST_FULL_FLAG_N),
	.FULL_FLAG_N(FULL_FLAG_N)
);

// file: tb/dcf_link_model.sv
// Purpose: writer and reader logic on the far side of the buffer
// Assumes: free-running 200 ns link clocks, as the device tolerates
// Notes:   pins change on the sixth falling core edge after a link rise, far from the next
`timescale 1ns/1ps
module dcf_link_model import dcf_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic [17:0] data_out,
	output logic             write_clk,
	output logic             read_clk,
	output logic             write_en_n,
	output logic             read_en_n,
	output logic             offset_load_n,
	output logic      [17:0] data_in
);
	logic [17:0] got [$]; // words seen on the read side, oldest first
	////////////////////////////////////////////////////////////
	// link clocks: phases unrelated to mclk and to each other
	initial
	begin
		write_clk = 1'b0;
		#7;
		forever #100 write_clk = ~write_clk;
	end
	initial
	begin
		read_clk = 1'b0;
		#61;
		forever #100 read_clk = ~read_clk;
	end
	// idle pins: nothing requested
	initial
	begin
		write_en_n    = 1'b1;
		read_en_n     = 1'b1;
		offset_load_n = 1'b1;
		data_in       = 18'h00000;
	end
	////////////////////////////////////////////////////////////
	// n words back to back; load selects the offset registers
	task automatic write_burst(input logic [17:0] base, input int n, input logic load);
		@(posedge write_clk);
		repeat (6) @(negedge mclk);
		offset_load_n = ~load;
		write_en_n    = 1'b0;
		data_in       = base;
		for (int i = 1; i <= n; i++)
		begin
			@(posedge write_clk);
			repeat (6) @(negedge mclk);
			data_in = base + 18'(i);
		end
		write_en_n    = 1'b1;
		offset_load_n = 1'b1;
		// a released bus must not look like the last word
		data_in       = ~data_in;
	endtask : write_burst
	// n reads; each word is taken once the answer has settled
	task automatic read_burst(input int n, input logic load);
		@(posedge read_clk);
		repeat (6) @(negedge mclk);
		offset_load_n = ~load;
		read_en_n     = 1'b0;
		repeat (n)
		begin
			@(posedge read_clk);
			repeat (6) @(negedge mclk);
			got.push_back(data_out);
		end
		read_en_n     = 1'b1;
		offset_load_n = 1'b1;
	endtask : read_burst
endmodule : dcf_link_model

// file: tb/testbench.sv
// Purpose: self-checking bench for the dual-clock buffer
// Assumes: smaller depth, so a complete fill stays short
// Notes:   inputs other than the link clocks change at the falling core edge only
`timescale 1ns/1ps
`include "dcf_defs.svh"
module testbench import dcf_pkg::*;
;
	localparam int DEPTH = 8192;
	localparam int OFFS  = `DCF_OFFSET_DEFAULT;
	logic          MCLK, ARST_N, CKE, OUT_EN_N, SYNC_FLAG_SELECT, REPLAY_PULSE;
	logic          WRITE_CLK, READ_CLK, WRITE_EN_N, READ_EN_N, OFFSET_LOAD_N, DATA_OUT_OE;
	logic [17:0]   DATA_IN, DATA_OUT;
	dcf_flags_type flg;             // all five flags, active low
	int            n_errors    = 0;
	int            check_count = 0;
	////////////////////////////////////////////////////////////
	dcf_buffer #(.DEPTH(DEPTH)) u_dut
	(
		.MCLK(MCLK), .ARST_N(ARST_N), .CKE(CKE), .WRITE_CLK(WRITE_CLK),
		.READ_CLK(READ_CLK), .WRITE_EN_N(WRITE_EN_N), .READ_EN_N(READ_EN_N),
		.OFFSET_LOAD_N(OFFSET_LOAD_N), .OUT_EN_N(OUT_EN_N),
		.SYNC_FLAG_SELECT(SYNC_FLAG_SELECT), .REPLAY_PULSE(REPLAY_PULSE),
		.DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT), .DATA_OUT_OE(DATA_OUT_OE),
		.EMPTY_FLAG_N(flg.empty_n), .ALMOST_EMPTY_FLAG_N(flg.almost_empty_n),
		.HALF_FULL_FLAG_N(flg.half_full_n), .ALMOST_FULL_FLAG_N(flg.almost_full_n),
		.FULL_FLAG_N(flg.full_n)
	);
	dcf_link_model u_link
	(
		.mclk(MCLK), .data_out(DATA_OUT), .write_clk(WRITE_CLK), .read_clk(READ_CLK),
		.write_en_n(WRITE_EN_N), .read_en_n(READ_EN_N), .offset_load_n(OFFSET_LOAD_N),
		.data_in(DATA_IN)
	);
	////////////////////////////////////////////////////////////
	initial
	begin
		MCLK = 1'b0;
		forever #12.5 MCLK = ~MCLK;
	end
	// hang guard: the whole run fits well inside this
	initial
	begin
		repeat (100000) @(posedge MCLK);
		n_errors++;
		$display("ERROR run length expected end seen hang");
		report_and_stop();
	end
	////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop
	task automatic check(input string what, input logic [17:0] exp, input logic [17:0] got);
		check_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// flag order: empty, almost empty, half, almost full, full
	task automatic check_flags(input logic [4:0] exp);
		check("flags", {13'h0000, exp}, {13'h0000, flg});
	endtask : check_flags
	// a missing word shows as a value no test writes
	task automatic check_word(input logic [17:0] exp);
		check("read word", exp, u_link.got.size() > 0 ? u_link.got.pop_front() : 18'h3FFFF);
	endtask : check_word
	task automatic settle();
		repeat (40) @(negedge MCLK);
	endtask : settle
	// link stays quiet while reset is low; flag mode is picked meanwhile
	task automatic do_reset(input logic sync);
		@(negedge MCLK);
		ARST_N           = 1'b0;
		SYNC_FLAG_SELECT = sync;
		repeat (10) @(negedge MCLK);
		check_flags(5'h07);
		check("data out", 18'h00000, DATA_OUT);
		check("output enable", 18'h00000, {17'h00000, DATA_OUT_OE});
		ARST_N = 1'b1;
		settle();
	endtask : do_reset
	task automatic fill(input int base, input int n, input logic [4:0] exp);
		u_link.write_burst(18'(base), n, 1'b0);
		settle();
		check_flags(exp);
	endtask : fill
	////////////////////////////////////////////////////////////
	initial
	begin
		ARST_N           = 1'b0;
		CKE              = 1'b1;
		OUT_EN_N         = 1'b1;
		SYNC_FLAG_SELECT = 1'b0;
		REPLAY_PULSE     = 1'b0;
		do_reset(1'b0);
		OUT_EN_N = 1'b0;
		repeat (6) @(negedge MCLK);
		check("output enable", 18'h00001, {17'h00000, DATA_OUT_OE});
		check("data out", 18'h00000, DATA_OUT);
		$display("test reset done");
		u_link.read_burst(2, 1'b1);
		check_word(18'(OFFS));
		check_word(18'(OFFS));
		u_link.write_burst(18'h00008, 2, 1'b1);
		u_link.write_burst(18'h3C003, 1, 1'b1);
		u_link.read_burst(2, 1'b1);
		check_word(18'h00003);
		check_word(18'h00009);
		$display("test offsets done");
		fill(18'h00100, 3, 5'h17);
		fill(18'h00103, 1, 5'h1F);
		u_link.read_burst(5, 1'b0);
		for (int i = 0; i < 4; i++)
			check_word(18'h00100 + 18'(i));
		check_word(18'h00103);
		settle();
		check_flags(5'h07);
		OUT_EN_N = 1'b1;
		repeat (6) @(negedge MCLK);
		check("output enable", 18'h00000, {17'h00000, DATA_OUT_OE});
		check("data out", 18'h00103, DATA_OUT);
		OUT_EN_N = 1'b0;
		// replay: the read side starts over from the first stored word
		REPLAY_PULSE = 1'b1;
		repeat (4) @(negedge MCLK);
		REPLAY_PULSE = 1'b0;
		settle();
		check_flags(5'h1F);
		u_link.read_burst(4, 1'b0);
		for (int i = 0; i < 4; i++)
			check_word(18'h00100 + 18'(i));
		$display("test data done");
		do_reset(1'b0);
		fill(0, DEPTH / 2, 5'h1F);
		fill(DEPTH / 2, 1, 5'h1B);
		fill(DEPTH / 2 + 1, DEPTH / 2 - OFFS - 2, 5'h1B);
		fill(DEPTH - OFFS - 1, 1, 5'h19);
		fill(DEPTH - OFFS, OFFS, 5'h18);
		fill(18'h2AAAA, 1, 5'h18);
		u_link.read_burst(1, 1'b0);
		check_word(18'h00000);
		settle();
		check_flags(5'h19);
		$display("test fill done");
		do_reset(1'b1);
		fill(0, OFFS + 1, 5'h1F);
		u_link.write_burst(18'h00080, 1, 1'b1);
		settle();
		check_flags(5'h17);
		$display("test async flags done");
		report_and_stop();
	end
endmodule : testbench
